// ===== core/dtwd_defines.vh
// register map, field positions, reset values and timing counts
`ifndef DTWD_DEFINES_VH
`define DTWD_DEFINES_VH
`define DTWD_THROT_OFS 12'h0A4
`define DTWD_MISC2_OFS 12'h0A8
`define DTWD_REFINT_OFS 12'h0B0
`define DTWD_THROT_RESET 32'h0000_0000
`define DTWD_MISC2_RESET 32'h0000_0000
`define DTWD_THR_MODE_LSB 12
`define DTWD_THR_MODE_MSB 14
`define DTWD_THR_BWCAP_BIT 11
`define DTWD_THR_SENSE_BIT 8
`define DTWD_M2_WRDLY_LSB 16
`define DTWD_M2_WRDLY_MSB 18
`define DTWD_M2_CS_LSB 8
`define DTWD_M2_CS_MSB 15
`define DTWD_REFI_78_BIT 0
`define DTWD_WINDOW_CLKS 100
`define DTWD_AXI_OKAY 2'h0
`define DTWD_AXI_DECERR 2'h3
`endif

// ===== core/dtwd_half_delay.v
// write-data launch delay line in half-clock steps
`timescale 1ns/100ps
module dtwd_half_delay #(
    parameter W = 32
) (
    input wire clk_in,
    input wire srst_in,
    input wire ce_in,
    input wire [2:0] sel_in,
    input wire valid_in,
    input wire [W-1:0] data_in,
    output reg valid_out,
    output reg [W-1:0] data_out
);
    // pos stage taps whole clocks, neg stage adds the half step
    reg [W:0] p1_r;
    reg [W:0] p2_r;
    reg [W:0] n0_r;
    reg [W:0] n1_r;
    wire [W:0] in_w;
    assign in_w = {valid_in, data_in};
    always @(posedge clk_in) begin
        if (srst_in) begin
            p1_r <= {(W+1){1'b0}};
            p2_r <= {(W+1){1'b0}};
        end else if (ce_in) begin
            p1_r <= in_w;
            p2_r <= p1_r;
        end
    end
    // 1.5 tap is the half step after the one-clock tap
    always @(negedge clk_in) begin
        if (srst_in) begin
            n0_r <= {(W+1){1'b0}};
            n1_r <= {(W+1){1'b0}};
        end else if (ce_in) begin
            n0_r <= in_w;
            n1_r <= p1_r;
        end
    end
    always @* begin
        case (sel_in) // see R4
            3'h1: {valid_out, data_out} = n0_r;
            3'h2: {valid_out, data_out} = p1_r;
            3'h3: {valid_out, data_out} = n1_r;
            3'h4: {valid_out, data_out} = p2_r;
            default: {valid_out, data_out} = in_w;
        endcase
    end
endmodule // dtwd_half_delay

// ===== core/dtwd_ctl.v
// thermal response, write-data delay and control-word chip selects
// Contract
// R1 - the alert input only counts while thermal sensing is enabled.
// R2 - sensed alert doubles refresh rate when interval is 7.8 us.
// R3 - sensed alert throttles commands per the 3-bit setting.
// R4 - write data to the phy is delayed 0, 0.5, 1, 1.5 or 2 clocks.
// R5 - software writes only 000b to 100b into the delay field.
// R6 - software picks the delay from the read pointer start value.
// R7 - for start 0100b software picks 001b if perf state nonzero else 010b.
// R8 - the chip-select field picks chip selects for control words.
// R9 - throttle averages over 100 clocks; setting 000b disables it.
// R10 - bandwidth cap applies throttling regardless of the alert.
// R11 - the alert pin is active low.
//
// Our own choice: the AXI4-Lite register port.
`timescale 1ns/100ps
`include "dtwd_defines.vh"
module dtwd_ctl #(
    parameter DW = 32
) (
    input wire clk_in,
    input wire srst_in,
    input wire ce_in,
    input wire [11:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [11:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    input wire thermal_alert_n_in,
    input wire send_control_word_in,
    input wire [7:0] rank_cs_in,
    output wire [7:0] cs_sel_out,
    input wire wr_valid_in,
    input wire [DW-1:0] wr_data_in,
    output wire phy_wr_valid_out,
    output wire [DW-1:0] phy_wr_data_out,
    output reg thermal_active_out,
    output reg refresh_double_out,
    output reg throttle_active_out,
    output reg [2:0] command_throttle_setting_out,
    output reg cmd_allow_out
);
    reg [31:0] throt_r;
    reg [31:0] misc2_r;
    reg refi_78_r;
    reg [2:0] alert_sync_r;
    reg alert_n_r;
    reg [11:0] aw_addr_r;
    reg aw_have_r;
    reg [31:0] w_data_r;
    reg [3:0] w_strb_r;
    reg w_have_r;
    reg [6:0] win_cnt_r;
    reg [6:0] used_cnt_r;
    reg [6:0] quota;
    wire thermal_sensing_enable;
    wire bandwidth_cap_enable;
    wire [2:0] command_throttle_setting;
    wire [2:0] write_data_launch_delay;
    wire [7:0] control_word_chip_selects;
    wire alert_seen;
    wire throttle_on;
    wire do_write;
    wire [31:0] wmask;

    assign thermal_sensing_enable = throt_r[`DTWD_THR_SENSE_BIT];
    assign bandwidth_cap_enable = throt_r[`DTWD_THR_BWCAP_BIT];
    assign command_throttle_setting =
        throt_r[`DTWD_THR_MODE_MSB:`DTWD_THR_MODE_LSB];
    assign write_data_launch_delay =
        misc2_r[`DTWD_M2_WRDLY_MSB:`DTWD_M2_WRDLY_LSB];
    assign control_word_chip_selects =
        misc2_r[`DTWD_M2_CS_MSB:`DTWD_M2_CS_LSB];

    // alert pin through three flops, change taken when 2nd and 3rd agree
    always @(posedge clk_in) begin
        if (srst_in) begin
            alert_sync_r <= 3'h7;
            alert_n_r <= 1'b1;
        end else if (ce_in) begin
            alert_sync_r <= {alert_sync_r[1:0], thermal_alert_n_in};
            if (alert_sync_r[1] == alert_sync_r[2]) begin
                alert_n_r <= alert_sync_r[2];
            end
        end
    end

    assign alert_seen = thermal_sensing_enable & ~alert_n_r; // see R1 see R11
    assign throttle_on = (alert_seen | bandwidth_cap_enable) // see R10
        & (command_throttle_setting != 3'h0); // see R9

    // axi-lite write: address and data taken in either order
    assign s_axi_awready = ~aw_have_r & ~s_axi_bvalid;
    assign s_axi_wready = ~w_have_r & ~s_axi_bvalid;
    assign do_write = aw_have_r & w_have_r & ~s_axi_bvalid;
    assign wmask = {{8{w_strb_r[3]}}, {8{w_strb_r[2]}},
        {8{w_strb_r[1]}}, {8{w_strb_r[0]}}};
    assign s_axi_arready = ~s_axi_rvalid;

    always @(posedge clk_in) begin
        if (srst_in) begin
            aw_have_r <= 1'b0;
            w_have_r <= 1'b0;
            aw_addr_r <= 12'h000;
            w_data_r <= 32'h0000_0000;
            w_strb_r <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `DTWD_AXI_OKAY;
            throt_r <= `DTWD_THROT_RESET;
            misc2_r <= `DTWD_MISC2_RESET;
            refi_78_r <= 1'b0;
        end else if (ce_in) begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_have_r <= 1'b1;
                aw_addr_r <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_have_r <= 1'b1;
                w_data_r <= s_axi_wdata;
                w_strb_r <= s_axi_wstrb;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
            if (do_write) begin
                aw_have_r <= 1'b0;
                w_have_r <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= `DTWD_AXI_OKAY;
                if (aw_addr_r[11:2] == `DTWD_THROT_OFS >> 2) begin
                    // only mode, cap and enable bits are writable
                    throt_r <= (throt_r & ~wmask)
                        | (w_data_r & wmask & 32'h0000_7900);
                end else if (aw_addr_r[11:2] == `DTWD_MISC2_OFS >> 2) begin
                    misc2_r <= (misc2_r & ~wmask)
                        | (w_data_r & wmask & 32'h0007_FF00);
                end else if (aw_addr_r[11:2] == `DTWD_REFINT_OFS >> 2) begin
                    if (w_strb_r[0]) begin
                        refi_78_r <= w_data_r[`DTWD_REFI_78_BIT];
                    end
                end else begin
                    s_axi_bresp <= `DTWD_AXI_DECERR;
                end
            end
        end
    end

    // axi-lite read, one cycle after address taken
    always @(posedge clk_in) begin
        if (srst_in) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `DTWD_AXI_OKAY;
        end else if (ce_in) begin
            if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= `DTWD_AXI_OKAY;
                if (s_axi_araddr[11:2] == `DTWD_THROT_OFS >> 2) begin
                    s_axi_rdata <= throt_r;
                end else if (s_axi_araddr[11:2] == `DTWD_MISC2_OFS >> 2) begin
                    s_axi_rdata <= misc2_r;
                end else if (s_axi_araddr[11:2] == `DTWD_REFINT_OFS >> 2) begin
                    // status: live alert, throttle and refresh state
                    s_axi_rdata <= {28'h0000000, refresh_double_out,
                        throttle_active_out, alert_seen, refi_78_r};
                end else begin
                    s_axi_rdata <= 32'h0000_0000;
                    s_axi_rresp <= `DTWD_AXI_DECERR;
                end
            end
        end
    end

    // percentage quota of allowed commands per 100-clock window
    always @* begin
        case (command_throttle_setting) // see R3
            3'h1: quota = 7'd70;
            3'h2: quota = 7'd50;
            3'h3: quota = 7'd40;
            3'h4: quota = 7'd30;
            3'h5: quota = 7'd20;
            3'h6: quota = 7'd10;
            3'h7: quota = 7'd0;
            default: quota = 7'd100;
        endcase
    end

    // window counter; commands allowed while used < quota
    always @(posedge clk_in) begin
        if (srst_in) begin
            win_cnt_r <= 7'd0;
            used_cnt_r <= 7'd0;
            cmd_allow_out <= 1'b1;
            thermal_active_out <= 1'b0;
            refresh_double_out <= 1'b0;
            throttle_active_out <= 1'b0;
            command_throttle_setting_out <= 3'h0;
        end else if (ce_in) begin
            thermal_active_out <= alert_seen;
            refresh_double_out <= alert_seen & refi_78_r; // see R2
            throttle_active_out <= throttle_on;
            command_throttle_setting_out <= command_throttle_setting;
            if (win_cnt_r == `DTWD_WINDOW_CLKS - 1) begin // see R9
                win_cnt_r <= 7'd0;
                used_cnt_r <= 7'd0;
            end else begin
                win_cnt_r <= win_cnt_r + 7'd1;
                if (cmd_allow_out) begin
                    used_cnt_r <= used_cnt_r + 7'd1;
                end
            end
            cmd_allow_out <= ~throttle_on
                | (used_cnt_r + 7'd1 < quota); // see R3
        end
    end

    // chip selects for control-word programming
    genvar g;
    generate
        for (g = 0; g < 8; g = g + 1) begin : g_cs
            assign cs_sel_out[g] = send_control_word_in
                ? control_word_chip_selects[g] : rank_cs_in[g]; // see R8
        end
    endgenerate

    dtwd_half_delay #(
        .W(DW)
    ) u_dly (
        .clk_in(clk_in),
        .srst_in(srst_in),
        .ce_in(ce_in),
        .sel_in(write_data_launch_delay),
        .valid_in(wr_valid_in),
        .data_in(wr_data_in),
        .valid_out(phy_wr_valid_out),
        .data_out(phy_wr_data_out)
    );
endmodule // dtwd_ctl

// ===== test/dtwd_ctl_checker.sv
// port assertions for the thermal and write-delay control block
`timescale 1ns/100ps
module dtwd_ctl_checker (
    input wire clk_in,
    input wire srst_in,
    input wire s_axi_arvalid,
    input wire s_axi_arready,
    input wire s_axi_rvalid,
    input wire s_axi_rready,
    input wire [31:0] s_axi_rdata,
    input wire thermal_alert_n_in,
    input wire send_control_word_in,
    input wire [7:0] rank_cs_in,
    input wire [7:0] cs_sel_out,
    input wire thermal_active_out,
    input wire refresh_double_out,
    input wire throttle_active_out,
    input wire [2:0] command_throttle_setting_out,
    input wire cmd_allow_out
);
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (srst_in);
    a_cs_pass: assert property (
        !send_control_word_in |-> cs_sel_out == rank_cs_in)
        else $error("chip selects not from rank input");
    a_refresh_src: assert property (
        refresh_double_out |-> thermal_active_out || $past(thermal_active_out))
        else $error("refresh doubled without thermal event");
    a_alert_idle: assert property (
        thermal_alert_n_in [*6] |-> !thermal_active_out)
        else $error("thermal active with alert pin high");
    a_thr_zero: assert property (
        (command_throttle_setting_out == 3'h0) [*2] |-> !throttle_active_out)
        else $error("throttle active at setting zero");
    a_thr_free: assert property (
        (command_throttle_setting_out == 3'h0) [*3] |-> cmd_allow_out)
        else $error("commands held at setting zero");
    a_thr_block: assert property (
        (throttle_active_out && command_throttle_setting_out == 3'h7) [*3]
        |-> !cmd_allow_out) else $error("command allowed at full throttle");
    a_rd_answer: assert property (
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    a_rd_hold: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read dropped");
    c_refresh: cover property (refresh_double_out);
    c_throttle: cover property (throttle_active_out && !cmd_allow_out);
    c_ctl_word: cover property (send_control_word_in);
endmodule // dtwd_ctl_checker
bind dtwd_ctl dtwd_ctl_checker u_dtwd_ctl_checker (.clk_in, .srst_in,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready,
    .s_axi_rdata, .thermal_alert_n_in, .send_control_word_in, .rank_cs_in,
    .cs_sel_out, .thermal_active_out, .refresh_double_out,
    .throttle_active_out, .command_throttle_setting_out, .cmd_allow_out);

// ===== test/dtwd_dimm_sensor.sv
// memory module temperature sensor driving the alert line
`timescale 1ns/100ps
module dtwd_dimm_sensor (
    input wire clk_in,
    input wire hot_in,
    input wire [1:0] lag_in,
    output wire alert_n_out
);
    reg [3:0] hist_r = 4'h0;
    always @(posedge clk_in) begin
        hist_r <= {hist_r[2:0], hot_in};
    end
    // push-pull drive, low while hot, delayed by lag_in+1 clocks, high otherwise
    assign alert_n_out = hist_r[lag_in] ? 1'h0 : 1'h1;
endmodule // dtwd_dimm_sensor

// ===== test/dtwd_ctl_tb.sv
// self-checking bench for the thermal and write-delay control block
`timescale 1ns/100ps
`include "dtwd_defines.vh"
module dtwd_ctl_tb;
    reg clk_in = 1'h0, srst_in = 1'h1, hot = 1'h0, send_control_word_in = 1'h0;
    reg s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
    reg s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, wr_valid_in = 1'h0;
    reg [11:0] s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0;
    reg [31:0] s_axi_wdata = 32'h0, wr_data_in = 32'h0, rd_d, exp_d;
    reg [7:0] rank_cs_in = 8'h0;
    reg [1:0] lag = 2'h0, rd_s, wr_s;
    reg [3:0] rptr;
    reg [2:0] dly;
    integer seed = 32'h5778, n_errors = 0, compares = 0, i, k;
    wire s_axi_awready, s_axi_wready, s_axi_arready, s_axi_bvalid;
    wire s_axi_rvalid, phy_wr_valid_out, thermal_active_out, cmd_allow_out;
    wire refresh_double_out, throttle_active_out, thermal_alert_n_in;
    wire [1:0] s_axi_bresp, s_axi_rresp;
    wire [31:0] s_axi_rdata, phy_wr_data_out;
    wire [7:0] cs_sel_out;
    wire [2:0] command_throttle_setting_out;
    always #4 clk_in = ~clk_in;
    dtwd_dimm_sensor u_dtwd_dimm_sensor (.clk_in, .hot_in(hot),
        .lag_in(lag), .alert_n_out(thermal_alert_n_in));
    dtwd_ctl u_dtwd_ctl (.clk_in, .srst_in, .ce_in(1'h1), .s_axi_awaddr,
        .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hF),
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .thermal_alert_n_in, .send_control_word_in, .rank_cs_in, .cs_sel_out,
        .wr_valid_in, .wr_data_in, .phy_wr_valid_out, .phy_wr_data_out,
        .thermal_active_out, .refresh_double_out, .throttle_active_out,
        .command_throttle_setting_out, .cmd_allow_out);
    function [6:0] allow_exp(input [2:0] s);
        allow_exp = s == 3'h0 ? 7'h64 : s == 3'h1 ? 7'h46 :
            s == 3'h2 ? 7'h32 : 7'h46 - 7'hA * s;
    endfunction
    // software choice of launch delay from read pointer start value
    function [2:0] dly_pick(input [3:0] rp, input ps_nz);
        dly_pick = rp == 4'h6 ? 3'h0 : rp == 4'h5 ? 3'h1 :
            rp == 4'h4 ? (ps_nz ? 3'h1 : 3'h2) :
            rp == 4'h3 ? 3'h3 : 3'h4;
    endfunction
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        compares = compares + 1;
        if (g !== e) begin
            n_errors = n_errors + 1;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task wr(input [11:0] a, input [31:0] d);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        do begin
            @(posedge clk_in);
            if (s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wready) s_axi_wvalid <= 1'h0;
        end while (!s_axi_bvalid);
        wr_s = s_axi_bresp;
        s_axi_bready <= 1'h0;
        @(posedge clk_in);
    endtask
    task rdc(input [11:0] a, input [31:0] e, input [1:0] r);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        do begin
            @(posedge clk_in);
            if (s_axi_arready) s_axi_arvalid <= 1'h0;
        end while (!s_axi_rvalid);
        rd_d = s_axi_rdata;
        rd_s = s_axi_rresp;
        s_axi_rready <= 1'h0;
        @(posedge clk_in);
        chk("rdata", e, rd_d);
        chk("rresp", {30'h0, r}, {30'h0, rd_s});
    endtask
    // count permitted command slots over one averaging window
    task tcount(input [6:0] e);
        repeat (210) @(posedge clk_in);
        k = 0;
        repeat (100) begin
            @(posedge clk_in);
            k = k + cmd_allow_out;
        end
        chk("allowed", e, k);
    endtask
    task summarize;
        $display("errors %0d compares %0d", n_errors, compares);
        if (n_errors == 0 && compares > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin
        repeat (15000) @(posedge clk_in);
        n_errors = n_errors + 1;
        summarize;
    end
    initial begin
        repeat (12) @(posedge clk_in);
        srst_in <= 1'h0;
        @(posedge clk_in);
        rdc(`DTWD_THROT_OFS, `DTWD_THROT_RESET, `DTWD_AXI_OKAY);
        rdc(`DTWD_MISC2_OFS, `DTWD_MISC2_RESET, `DTWD_AXI_OKAY);
        wr(`DTWD_THROT_OFS, 32'hFFFFFFFF);
        chk("bresp", `DTWD_AXI_OKAY, wr_s);
        rdc(`DTWD_THROT_OFS, 32'h00007900, `DTWD_AXI_OKAY);
        wr(`DTWD_MISC2_OFS, 32'hFFFFFFFF);
        rdc(`DTWD_MISC2_OFS, 32'h0007FF00, `DTWD_AXI_OKAY);
        wr(12'h0FC, 32'hFFFFFFFF);
        chk("bresp", `DTWD_AXI_DECERR, wr_s);
        rdc(12'h0FC, 32'h0, `DTWD_AXI_DECERR);
        for (i = 0; i < 6; i = i + 1) begin
            exp_d = $random(seed);
            wr(`DTWD_MISC2_OFS, {16'h0, exp_d[15:8], 8'h0});
            rank_cs_in <= exp_d[7:0];
            send_control_word_in <= i[0];
            #1;
            chk("cs", i[0] ? exp_d[15:8] : exp_d[7:0], cs_sel_out);
        end
        send_control_word_in <= 1'h0;
        for (i = 0; i < 6; i = i + 1) begin
            rptr = i < 3 ? 4'h6 - i[3:0] : 4'h7 - i[3:0];
            dly = dly_pick(rptr, i == 2);
            wr(`DTWD_MISC2_OFS, {13'h0, dly, 16'h0});
            wr_data_in <= $random(seed);
            wr_valid_in <= 1'h1;
            #0.5;
            k = 0;
            while (phy_wr_valid_out !== 1'h1 && k < 40) begin
                #1;
                k = k + 1;
            end
            chk("delay", dly * 4, k);
            chk("wdata", wr_data_in, phy_wr_data_out);
            @(posedge clk_in);
            wr_valid_in <= 1'h0;
            repeat (4) @(posedge clk_in);
        end
        lag <= $random(seed);
        wr(`DTWD_THROT_OFS, 32'h00001000);
        hot <= 1'h1;
        repeat (12) @(posedge clk_in);
        chk("thermal", 32'h0, thermal_active_out);
        tcount(allow_exp(3'h0));
        wr(`DTWD_THROT_OFS, 32'h00001100);
        repeat (12) @(posedge clk_in);
        chk("thermal", 32'h1, thermal_active_out);
        chk("refresh", 32'h0, refresh_double_out);
        tcount(allow_exp(3'h1));
        wr(`DTWD_REFINT_OFS, 32'h1);
        repeat (4) @(posedge clk_in);
        chk("refresh", 32'h1, refresh_double_out);
        hot <= 1'h0;
        repeat (12) @(posedge clk_in);
        chk("thermal", 32'h0, thermal_active_out);
        chk("refresh", 32'h0, refresh_double_out);
        for (i = 0; i < 8; i = i + 1) begin
            wr(`DTWD_THROT_OFS, (i << 12) | 32'h800);
            tcount(allow_exp(i[2:0]));
            chk("setting", i[2:0], command_throttle_setting_out);
            chk("throttle", i != 0, throttle_active_out);
        end
        summarize;
    end
endmodule // dtwd_ctl_tb
